// file: design/lbps_top.sv
`timescale 1ns/10ps

// Operation
// - Second indicator selector: 000 drives the pin, 111 disables it, reset value 7.
// - The receive frame-start selector puts the marker on one of 15 pins, none on 1111.
// - A separate transmit frame-start selector uses the same mapping and resets to off.
// - First indicator on-phase lasts the on field, bits 15:8, times 4 ms; reset 0x36.
// - First indicator off-phase lasts the off field, bits 7:0, times 4 ms; reset 0x36.
// - With phase setting 0 a blinking indicator starts off, then on, and repeats.
// - With phase setting 1 a blinking indicator starts on, then off, and repeats.
// - With both time fields zero the indicator follows the selected internal signal live.
// - A link-and-activity source lights the indicator while link is up and idle, else off.
// - An activity source keeps the indicator off when idle and blinks it with activity, or holds it on when both time fields are zero.
// - A cleared indicator enable holds that indicator off whatever its source or timing, unless a frame-start marker is routed to its pin.
module lbps_top
  import lbps_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = LBPS_TICK_CYCLES
) (
  input  wire logic        clock,                   // Device clock
  input  wire logic        rst,                     // Async reset, active high
  input  wire logic [15:0] reg_addr,                // Register address
  input  wire logic        reg_wr,                  // Register write strobe
  input  wire logic        reg_rd,                  // Register read strobe
  input  wire logic [15:0] reg_wdata,               // Register write data
  output logic      [15:0] reg_rdata,               // Register read data
  input  wire logic        link_up,                 // Link status
  input  wire logic        activity,                // Activity indication
  input  wire logic        rx_frame_start,          // Receive start-of-frame marker
  input  wire logic        tx_frame_start,          // Transmit start-of-frame marker
  input  wire logic        first_indicator_enable,  // First LED enable
  input  wire logic        second_indicator_enable, // Second LED enable
  input  wire logic        indicator_blink_phase,   // 0 starts off, 1 starts on
  input  wire lbps_src_t   indicator_source_select, // First LED source
  input  wire logic        second_indicator_source, // Second LED function level
  output logic             link_status_pin,         // Link status pin
  output logic             first_indicator_pin,     // First LED pin
  output logic             second_indicator_pin,    // Second LED pin
  output logic             second_indicator_oe_n,   // Second LED enable, low drives
  output logic      [11:0] mac_sop_pin,             // Marker onto MAC pins
  output logic      [11:0] mac_sop_pin_en           // MAC pin carries marker
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // One-hot pin decode of a frame-start selector, empty when off
  function automatic logic [14:0] sop_decode(input logic [3:0] code);
    logic [14:0] hot;
    hot = 15'h0000;
    if (code != LBPS_SOP_OFF) begin
      hot[code] = 1'b1;
    end
    return hot;
  endfunction

  // ------------------------------------------------------------
  // Register file
  // ------------------------------------------------------------
  lbps_pinmux_t    pinmux, next_pinmux;
  lbps_sop_t       sop, next_sop;
  lbps_blink_cfg_t blink, next_blink;
  logic [15:0]     next_reg_rdata;

  // Write decode and registered read data
  always_comb begin
    next_pinmux    = pinmux;
    next_sop       = sop;
    next_blink     = blink;
    next_reg_rdata = reg_rdata;
    if (reg_wr) begin
      unique case (reg_addr)
        LBPS_PINMUX1_ADDR: next_pinmux = reg_wdata[3:0];
        LBPS_PINMUX2_ADDR: next_sop    = reg_wdata[7:0];
        LBPS_BLINK0_ADDR:  next_blink  = reg_wdata;
        default: ;
      endcase
    end
    if (reg_rd) begin
      unique case (reg_addr)
        LBPS_PINMUX1_ADDR: next_reg_rdata = {LBPS_PINMUX1_RSVD, pinmux};
        LBPS_PINMUX2_ADDR: next_reg_rdata = {8'h00, sop};
        LBPS_BLINK0_ADDR:  next_reg_rdata = blink;
        default:           next_reg_rdata = 16'h0000;
      endcase
    end
  end

  // Register state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      pinmux    <= LBPS_PINMUX1_RST[3:0];
      sop       <= LBPS_PINMUX2_RST[7:0];
      blink     <= LBPS_BLINK0_RST;
      reg_rdata <= 16'h0000;
    end else begin
      pinmux    <= next_pinmux;
      sop       <= next_sop;
      blink     <= next_blink;
      reg_rdata <= next_reg_rdata;
    end
  end

  // ------------------------------------------------------------
  // Blink engine
  // ------------------------------------------------------------
  lbps_blink_t state, next_state;
  logic [19:0] tick_cnt, next_tick_cnt;
  logic [7:0]  phase_cnt, next_phase_cnt;
  logic        tick;
  logic        timing_zero;
  logic        blink_req;
  logic        live;
  logic [7:0]  phase_len;

  // Source level and blink request
  always_comb begin
    timing_zero = (blink.on_ticks == 8'h00) && (blink.off_ticks == 8'h00);
    unique case (indicator_source_select)
      SRC_ACT:      live = activity;
      SRC_LINK_ACT: live = link_up && !activity;
      SRC_LINK:     live = link_up;
      SRC_BLINK:    live = 1'b1;
    endcase
    blink_req = first_indicator_enable && !timing_zero &&
                ((indicator_source_select == SRC_BLINK) ||
                 (indicator_source_select == SRC_ACT && activity));
    tick      = (tick_cnt == 20'(TICK_CYCLES - 1));
    phase_len = (state == BL_ON) ? blink.on_ticks : blink.off_ticks;
  end

  // Phase sequencing, 4 ms ticks counted per phase
  always_comb begin
    next_state     = state;
    next_tick_cnt  = tick ? 20'h00000 : tick_cnt + 20'h00001;
    next_phase_cnt = phase_cnt;
    if (!blink_req) begin
      next_state     = BL_IDLE;
      next_tick_cnt  = 20'h00000;
      next_phase_cnt = 8'h00;
    end else begin
      unique case (state)
        BL_IDLE: begin
          next_state     = indicator_blink_phase ? BL_ON : BL_OFF;
          next_tick_cnt  = 20'h00000;
          next_phase_cnt = 8'h00;
        end
        BL_OFF, BL_ON: begin
          if (tick) begin
            if (9'(phase_cnt) + 9'h001 >= 9'(phase_len)) begin
              next_state     = (state == BL_ON) ? BL_OFF : BL_ON;
              next_phase_cnt = 8'h00;
            end else begin
              next_phase_cnt = phase_cnt + 8'h01;
            end
          end
        end
        default: next_state = BL_IDLE;
      endcase
    end
  end

  // Blink state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state     <= BL_IDLE;
      tick_cnt  <= 20'h00000;
      phase_cnt <= 8'h00;
    end else begin
      state     <= next_state;
      tick_cnt  <= next_tick_cnt;
      phase_cnt <= next_phase_cnt;
    end
  end

  // ------------------------------------------------------------
  // Pin outputs
  // ------------------------------------------------------------
  logic [14:0] sop_en, sop_val;
  logic        led0_val, led1_val, led1_drive, link_val;
  logic        next_link_pin, next_led0_pin, next_led1_pin, next_led1_oe_n;
  logic [11:0] next_mac_sop, next_mac_sop_en;

  // Marker routing and pin levels
  always_comb begin
    sop_en  = sop_decode(sop.rx_sel) | sop_decode(sop.tx_sel);
    sop_val = (sop_decode(sop.rx_sel) & {15{rx_frame_start}}) |
              (sop_decode(sop.tx_sel) & {15{tx_frame_start}});
    if (!first_indicator_enable) begin
      led0_val = 1'b0;
    end else if (timing_zero || !blink_req) begin
      led0_val = live;
    end else begin
      led0_val = (state == BL_ON);
    end
    link_val   = link_up ^ pinmux.link_pol;
    led1_val   = second_indicator_enable && second_indicator_source;
    led1_drive = (pinmux.led1_sel == LBPS_LED1_DRIVE);
    next_link_pin   = sop_en[LBPS_PIN_LINK] ? sop_val[LBPS_PIN_LINK] : link_val;
    next_led0_pin   = sop_en[LBPS_PIN_LED0] ? sop_val[LBPS_PIN_LED0] : led0_val;
    next_led1_pin   = sop_en[LBPS_PIN_LED1] ? sop_val[LBPS_PIN_LED1] : led1_val;
    next_led1_oe_n  = !(sop_en[LBPS_PIN_LED1] || led1_drive);
    next_mac_sop    = sop_val[LBPS_MAC_PINS-1:0];
    next_mac_sop_en = sop_en[LBPS_MAC_PINS-1:0];
  end

  // Registered pins
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      link_status_pin       <= 1'b0;
      first_indicator_pin   <= 1'b0;
      second_indicator_pin  <= 1'b0;
      second_indicator_oe_n <= 1'b1;
      mac_sop_pin           <= 12'h000;
      mac_sop_pin_en        <= 12'h000;
    end else begin
      link_status_pin       <= next_link_pin;
      first_indicator_pin   <= next_led0_pin;
      second_indicator_pin  <= next_led1_pin;
      second_indicator_oe_n <= next_led1_oe_n;
      mac_sop_pin           <= next_mac_sop;
      mac_sop_pin_en        <= next_mac_sop_en;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  chk_led1_disabled: assert property (
    (pinmux.led1_sel != LBPS_LED1_DRIVE && !sop_en[LBPS_PIN_LED1]) |=> second_indicator_oe_n)
    else $error("second indicator driven while not selected");

  chk_rx_sop_route: assert property (
    (sop.rx_sel == 4'h4 && rx_frame_start) |=> (mac_sop_pin_en[4] && mac_sop_pin[4]))
    else $error("receive marker missing on selected pin");

  chk_sop_all_off: assert property (
    (sop.rx_sel == LBPS_SOP_OFF && sop.tx_sel == LBPS_SOP_OFF) |=> (mac_sop_pin_en == 12'h000))
    else $error("marker routed while both selectors off");

  chk_on_phase_end: assert property (
    (blink_req && state == BL_ON && tick && 9'(phase_cnt) + 9'h001 >= 9'(blink.on_ticks))
    |=> state == BL_OFF)
    else $error("on phase did not end at its length");

  chk_off_phase_end: assert property (
    (blink_req && state == BL_OFF && tick && 9'(phase_cnt) + 9'h001 >= 9'(blink.off_ticks))
    |=> state == BL_ON)
    else $error("off phase did not end at its length");

  chk_off_phase_hold: assert property (
    (blink_req && state == BL_OFF && tick && 9'(phase_cnt) + 9'h001 < 9'(blink.off_ticks))
    ##1 blink_req |-> (state == BL_OFF && phase_cnt == $past(phase_cnt) + 8'h01))
    else $error("off phase ended early");

  chk_start_off: assert property (
    (state == BL_IDLE && blink_req && !indicator_blink_phase) |=> state == BL_OFF)
    else $error("blink did not start with off phase");

  chk_start_on: assert property (
    (state == BL_IDLE && blink_req && indicator_blink_phase) |=> state == BL_ON)
    else $error("blink did not start with on phase");

  chk_live_follow: assert property (
    (first_indicator_enable && timing_zero && !sop_en[LBPS_PIN_LED0])
    |=> first_indicator_pin == $past(live))
    else $error("indicator not following live signal");

  chk_link_act_off: assert property (
    (first_indicator_enable && indicator_source_select == SRC_LINK_ACT &&
     (!link_up || activity) && !sop_en[LBPS_PIN_LED0]) |=> !first_indicator_pin)
    else $error("link activity indicator lit on loss or activity");

  chk_act_idle_off: assert property (
    (indicator_source_select == SRC_ACT && !activity && !sop_en[LBPS_PIN_LED0])
    |=> !first_indicator_pin)
    else $error("activity indicator lit while idle");

  chk_link_polarity: assert property (
    !sop_en[LBPS_PIN_LINK] |=> link_status_pin == ($past(link_up) ^ $past(pinmux.link_pol)))
    else $error("link pin polarity wrong");

  chk_led0_disable: assert property (
    (!first_indicator_enable && !sop_en[LBPS_PIN_LED0]) [*2] |-> !first_indicator_pin)
    else $error("disabled indicator lit");

  chk_led1_driven: assert property (
    (pinmux.led1_sel == LBPS_LED1_DRIVE) |=> !second_indicator_oe_n)
    else $error("second indicator not driven while selected");

  chk_tx_sop_route: assert property (
    (sop.tx_sel == 4'h7 && tx_frame_start) |=> (mac_sop_pin_en[7] && mac_sop_pin[7]))
    else $error("transmit marker missing on selected pin");

  chk_sop_led0_route: assert property (
    (sop.rx_sel == 4'hD && sop.tx_sel != 4'hD)
    |=> first_indicator_pin == $past(rx_frame_start))
    else $error("receive marker missing on first indicator pin");

  chk_led1_enable_off: assert property (
    (!second_indicator_enable && !sop_en[LBPS_PIN_LED1]) |=> !second_indicator_pin)
    else $error("disabled second indicator lit");

endmodule

// file: design/lbps_pkg.sv
package lbps_pkg;

  // ------------------------------------------------------------
  // Register offsets and reset values
  // ------------------------------------------------------------
  localparam logic [15:0] LBPS_PINMUX1_ADDR  = 16'h8C56;
  localparam logic [15:0] LBPS_PINMUX2_ADDR  = 16'h8C57;
  localparam logic [15:0] LBPS_BLINK0_ADDR   = 16'h8C80;
  localparam logic [15:0] LBPS_PINMUX1_RST   = 16'h00FE;
  localparam logic [15:0] LBPS_PINMUX2_RST   = 16'h00FF;
  localparam logic [15:0] LBPS_BLINK0_RST    = 16'h3636;
  localparam logic [11:0] LBPS_PINMUX1_RSVD  = 12'h00F;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int LBPS_LED1_SEL_LSB = 1;
  localparam int LBPS_LINK_POL_BIT = 0;
  localparam int LBPS_RX_SOP_LSB   = 4;
  localparam int LBPS_TX_SOP_LSB   = 0;
  localparam int LBPS_ON_LSB       = 8;
  localparam int LBPS_OFF_LSB      = 0;

  // ------------------------------------------------------------
  // Selector codes and pin indices
  // ------------------------------------------------------------
  localparam logic [2:0] LBPS_LED1_DRIVE = 3'h0;
  localparam logic [2:0] LBPS_LED1_OFF   = 3'h7;
  localparam logic [3:0] LBPS_SOP_OFF    = 4'hF;
  localparam int LBPS_PIN_LINK = 12;
  localparam int LBPS_PIN_LED0 = 13;
  localparam int LBPS_PIN_LED1 = 14;
  localparam int LBPS_MAC_PINS = 12;

  // ------------------------------------------------------------
  // Blink time base
  // ------------------------------------------------------------
  localparam int unsigned LBPS_CLK_PERIOD_NS = 4;
  localparam int unsigned LBPS_TICK_MS       = 4;
  localparam int unsigned LBPS_TICK_NS       = LBPS_TICK_MS * 1000000;
  localparam int unsigned LBPS_TICK_CYCLES   = LBPS_TICK_NS / LBPS_CLK_PERIOD_NS;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    SRC_ACT      = 2'h0,
    SRC_LINK_ACT = 2'h1,
    SRC_LINK     = 2'h2,
    SRC_BLINK    = 2'h3
  } lbps_src_t;

  typedef enum logic [1:0] {BL_IDLE, BL_OFF, BL_ON} lbps_blink_t;

  typedef struct packed {
    logic [2:0] led1_sel;
    logic       link_pol;
  } lbps_pinmux_t;

  typedef struct packed {
    logic [3:0] rx_sel;
    logic [3:0] tx_sel;
  } lbps_sop_t;

  typedef struct packed {
    logic [7:0] on_ticks;
    logic [7:0] off_ticks;
  } lbps_blink_cfg_t;

endpackage

// file: dv/lbps_board_model.sv
`timescale 1ns/10ps

module lbps_board_model (
  input  wire logic        clock,     // Device clock
  input  wire logic        rst,       // Async reset
  input  wire logic        led0_pin,  // First LED drive
  input  wire logic        led1_pin,  // Second LED drive
  input  wire logic        led1_oe_n, // Second LED enable, low drives
  output logic             led1_wire, // Level seen on the board
  output logic             run_done,  // A run of one level just ended
  output logic             run_lvl,   // Level of the ended run
  output logic      [15:0] run_len    // Cycles the ended run lasted
);
  logic        prev_lvl;
  logic [15:0] cnt;

  // Released second LED line falls to its pull-down
  assign led1_wire = led1_oe_n ? 1'b0 : led1_pin;

  // Times each steady stretch of the first LED
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      prev_lvl <= 1'b0;
      cnt      <= 16'h0001;
      run_done <= 1'b0;
      run_lvl  <= 1'b0;
      run_len  <= 16'h0000;
    end else begin
      run_done <= (led0_pin != prev_lvl);
      prev_lvl <= led0_pin;
      if (led0_pin != prev_lvl) begin
        run_lvl <= prev_lvl;
        run_len <= cnt;
        cnt     <= 16'h0001;
      end else begin
        cnt <= cnt + 16'h0001;
      end
    end
  end
endmodule

// file: dv/led_blink_and_pin_select_tb.sv
`timescale 1ns/10ps

module led_blink_and_pin_select_tb;
  import lbps_pkg::*;
  localparam int unsigned TICKS = 8;
  logic        clock, rst, reg_wr, reg_rd, link_up, activity, rx_sop, tx_sop;
  logic        en0, en1, phase, src1, link_pin, led0_pin, led1_pin, led1_oe_n;
  logic        led1_wire, run_done, run_lvl, live_exp;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, run_len;
  logic [11:0] mac_pin, mac_en;
  lbps_src_t   src;
  int          fail_count, num_checks;

  lbps_top #(.TICK_CYCLES(TICKS)) dut (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .link_up(link_up), .activity(activity),
    .rx_frame_start(rx_sop), .tx_frame_start(tx_sop), .first_indicator_enable(en0),
    .second_indicator_enable(en1), .indicator_blink_phase(phase),
    .indicator_source_select(src), .second_indicator_source(src1),
    .link_status_pin(link_pin), .first_indicator_pin(led0_pin),
    .second_indicator_pin(led1_pin), .second_indicator_oe_n(led1_oe_n),
    .mac_sop_pin(mac_pin), .mac_sop_pin_en(mac_en));

  lbps_board_model board (
    .clock(clock), .rst(rst), .led0_pin(led0_pin), .led1_pin(led1_pin),
    .led1_oe_n(led1_oe_n), .led1_wire(led1_wire), .run_done(run_done),
    .run_lvl(run_lvl), .run_len(run_len));

  // Free-running device clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic step(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic reg_write(input logic [15:0] addr, input logic [15:0] data);
    reg_addr  = addr;
    reg_wdata = data;
    reg_wr    = 1'b1;
    step(1);
    reg_wr = 1'b0;
    step(1);
  endtask

  task automatic reg_check(input string name, input logic [15:0] addr, input logic [15:0] exp);
    reg_addr = addr;
    reg_rd   = 1'b1;
    step(1);
    reg_rd = 1'b0;
    step(1);
    check(name, exp, reg_rdata);
  endtask

  // Pins as the board sees them: link, first LED, second LED line, its enable
  task automatic pins(input string name, input logic [3:0] exp);
    check(name, {12'h000, exp}, {12'h000, link_pin, led0_pin, led1_wire, led1_oe_n});
  endtask

  task automatic measure(input logic lvl, input logic [15:0] exp);
    int i;
    for (i = 0; i < 300; i++) begin
      step(1);
      if (run_done === 1'b1 && run_lvl === lvl) break;
    end
    if (i == 300) begin
      fail_count++;
      results();
    end
    check("blink run", exp, run_len);
  endtask

  task automatic results();
    if (fail_count == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    {reg_wr, reg_rd, link_up, activity, rx_sop, tx_sop, phase} = 7'h00;
    {en0, en1, src1} = 3'h7;
    reg_addr  = 16'h0000;
    reg_wdata = 16'h0000;
    src       = SRC_ACT;
    rst       = 1'b1;
    step(5);
    rst = 1'b0;
    step(1);
    reg_check("pinmux1 reset", LBPS_PINMUX1_ADDR, 16'h00FE);
    reg_check("pinmux2 reset", LBPS_PINMUX2_ADDR, 16'h00FF);
    reg_check("blink reset", LBPS_BLINK0_ADDR, 16'h3636);
    pins("reset pins", 4'b0001);
    reg_write(16'h8C58, 16'hFFFF);
    reg_check("unmapped", 16'h8C58, 16'h0000);
    reg_write(LBPS_PINMUX1_ADDR, 16'hFFF1);
    reg_check("pinmux1 rw", LBPS_PINMUX1_ADDR, 16'h00F1);
    reg_write(LBPS_PINMUX2_ADDR, 16'hABCD);
    reg_check("pinmux2 rw", LBPS_PINMUX2_ADDR, 16'h00CD);
    reg_write(LBPS_PINMUX2_ADDR, 16'h00FF);
    reg_write(LBPS_BLINK0_ADDR, 16'h0000);
    reg_check("blink rw", LBPS_BLINK0_ADDR, 16'h0000);
    // Live sources with zero timing, inverted link pin, second LED driven from its source
    for (int k = 0; k < 12; k++) begin
      src      = (k < 4) ? SRC_ACT : (k < 8) ? SRC_LINK_ACT : SRC_LINK;
      link_up  = k[1];
      activity = k[0];
      src1     = k[2];
      step(1);
      live_exp = (k < 4) ? k[0] : (k < 8) ? (k[1] & ~k[0]) : k[1];
      pins("live", {~k[1], live_exp, k[2], 1'b0});
    end
    activity = 1'b0;
    {en0, en1} = 2'b00;
    step(1);
    pins("disabled", 4'b0000);
    {en0, en1} = 2'b11;
    reg_write(LBPS_PINMUX1_ADDR, 16'h000E);
    pins("second off", 4'b1101);
    // Markers onto each MAC pin, receive and transmit crossed
    for (int c = 0; c < 12; c++) begin
      reg_write(LBPS_PINMUX2_ADDR, {8'h00, 4'(c), 4'(11 - c)});
      rx_sop = 1'b1;
      step(1);
      check("rx mac pin", 16'(1) << c, {4'h0, mac_pin});
      check("mac enable", 16'(1 << c | 1 << (11 - c)), {4'h0, mac_en});
      rx_sop = 1'b0;
      tx_sop = 1'b1;
      step(1);
      check("tx mac pin", 16'(1) << (11 - c), {4'h0, mac_pin});
      tx_sop = 1'b0;
    end
    // Markers onto link and LED pins, then off
    {link_up, en0} = 2'b00;
    for (int c = 12; c < 16; c++) begin
      reg_write(LBPS_PINMUX2_ADDR, {8'h00, 4'(c), 4'hF});
      {rx_sop, tx_sop} = 2'b11;
      step(1);
      pins("marker pin", {c == 12, c == 13, c == 14, c != 14});
      check("marker mac", 16'h0000, {4'h0, mac_en});
      {rx_sop, tx_sop} = 2'b00;
    end
    // Blink with on 4 and off 5 ticks, both phase orders
    reg_write(LBPS_BLINK0_ADDR, 16'h0405);
    src = SRC_BLINK;
    for (int p = 0; p < 2; p++) begin
      en0 = 1'b0;
      step(2);
      check("blink held off", 16'h0000, {15'h0000, led0_pin});
      phase = p[0];
      en0   = 1'b1;
      step(4);
      check("blink start", 16'(p), {15'h0000, led0_pin});
      step(100);
      measure(1'b1, 16'(4 * TICKS));
      measure(1'b0, 16'(5 * TICKS));
    end
    results();
  end
endmodule
